//--- sfr_map_page_decoder.sv
`timescale 1ns/1ps
`include "sfr_map_defines.svh"
// Summary of operation
// - Claim direct accesses in the upper half, 128 register slots per area.
// - Two areas, standard and mapped, share the range for 256 slots.
// - Area comes from the map-select bit at address 8F, not the instruction.
// - Map-select is bit 0, read-write; 0 standard area, 1 mapped area.
// - Reset or a software write of 0 clears map-select; otherwise it holds until software writes it.
// - System control register resets to 04, selecting the standard area.
// - Bit 2 of system control always reads one.
// - Bits 7 to 5, 3 and 1 of system control always read zero.
// - The module page register's page field selects which port page responds.
// - Page count and registers per page are configurable per module.
// - Standard area, page 1: per port pull-direction select and pull enable.
// - Pull-direction selects reset to FF, port 3 to BF.
// - Pull enables reset C4, FF, 00, 40, 04, FF for ports 0 to 5.
// - Standard area, page 2: alternate-function select low, read-write, reset 00.
// - Page 2 alternate-function select high, at 86 and 91 etc., reset zero.
module sfr_map_page_decoder #(
   parameter int PAGE_BITS  = `PORT_PAGE_BITS,
   parameter int PORT_COUNT = 6
) (
   input  wire logic                        core_clk,
   input  wire logic                        rst_n,
   input  wire sfr_map_pkg::sfr_request_type sfr_req,
   output logic                             sfr_claim,
   output logic [7:0]                       sfr_rdata,
   output logic                             area_map_select,
   output logic [PAGE_BITS-1:0]             port_page,
   output sfr_map_pkg::port_bank_type       port_config
);
   import sfr_map_pkg::*;

   localparam logic [5:0][7:0] LOW_ADDR = {
      `PORT5_LOW_ADDR, `PORT4_LOW_ADDR, `PORT3_LOW_ADDR,
      `PORT2_LOW_ADDR, `PORT1_LOW_ADDR, `PORT0_LOW_ADDR};
   localparam logic [5:0][7:0] HIGH_ADDR = {
      `PORT5_HIGH_ADDR, `PORT4_HIGH_ADDR, `PORT3_HIGH_ADDR,
      `PORT2_HIGH_ADDR, `PORT1_HIGH_ADDR, `PORT0_HIGH_ADDR};

   localparam port_bank_type PORT_RESET = {
      `PORT5_PULL_DIRECTION_RESET, `PORT5_PULL_ENABLE_RESET,
      `ALT_FUNCTION_RESET, `ALT_FUNCTION_RESET,
      `PORT4_PULL_DIRECTION_RESET, `PORT4_PULL_ENABLE_RESET,
      `ALT_FUNCTION_RESET, `ALT_FUNCTION_RESET,
      `PORT3_PULL_DIRECTION_RESET, `PORT3_PULL_ENABLE_RESET,
      `ALT_FUNCTION_RESET, `ALT_FUNCTION_RESET,
      `PORT2_PULL_DIRECTION_RESET, `PORT2_PULL_ENABLE_RESET,
      `ALT_FUNCTION_RESET, `ALT_FUNCTION_RESET,
      `PORT1_PULL_DIRECTION_RESET, `PORT1_PULL_ENABLE_RESET,
      `ALT_FUNCTION_RESET, `ALT_FUNCTION_RESET,
      `PORT0_PULL_DIRECTION_RESET, `PORT0_PULL_ENABLE_RESET,
      `ALT_FUNCTION_RESET, `ALT_FUNCTION_RESET};

   localparam decoder_state_type RESET_STATE = '{
      area_map_select: 1'((`SYSTEM_CONTROL_ZERO_RESET >> `AREA_MAP_SELECT_BIT) & 8'h01),
      page:            `MODULE_PAGE_REGISTER_RESET,
      ports:           PORT_RESET,
      read_data:       `READ_DATA_RESET};

   localparam logic [7:0] PAGE_MASK = 8'((1 << PAGE_BITS) - 1);

   decoder_state_type state_reg;
   decoder_state_type state_next;

   logic       in_range;
   logic       standard_area;
   logic       sel_syscon;
   logic       sel_page;
   logic [5:0] sel_pds;
   logic [5:0] sel_pen;
   logic [5:0] sel_alo;
   logic [5:0] sel_ahi;
   logic [7:0] read_mux;
   logic [7:0] syscon_value;

   // Address decode against the currently selected area and port page.
   always_comb begin
      in_range      = sfr_req.addr[`SFR_AREA_MSB];
      standard_area = !state_reg.area_map_select;
      sel_syscon    = in_range && sfr_req.addr == `SYSTEM_CONTROL_ZERO_ADDR;
      sel_page      = in_range && standard_area
                      && sfr_req.addr == `MODULE_PAGE_REGISTER_ADDR;
      for (int i = 0; i < 6; i++) begin
         sel_pds[i] = 1'b0;
         sel_pen[i] = 1'b0;
         sel_alo[i] = 1'b0;
         sel_ahi[i] = 1'b0;
         if (i < PORT_COUNT && in_range && standard_area) begin
            if (state_reg.page == `PORT_PAGE_PULL) begin
               sel_pds[i] = sfr_req.addr == LOW_ADDR[i];
               sel_pen[i] = sfr_req.addr == HIGH_ADDR[i];
            end
            if (state_reg.page == `PORT_PAGE_ALT) begin
               sel_alo[i] = sfr_req.addr == LOW_ADDR[i];
               sel_ahi[i] = sfr_req.addr == HIGH_ADDR[i];
            end
         end
      end
   end

   // Read multiplexer; anything not selected reads zero.
   always_comb begin
      syscon_value = `SYSTEM_CONTROL_ZERO_FIXED
                     | (8'(state_reg.area_map_select) << `AREA_MAP_SELECT_BIT);
      read_mux = 8'h00;
      if (sel_syscon) begin
         read_mux = syscon_value;
      end
      if (sel_page) begin
         read_mux = state_reg.page & PAGE_MASK;
      end
      for (int i = 0; i < 6; i++) begin
         if (sel_pds[i]) begin
            read_mux = state_reg.ports[i].pull_direction_select;
         end
         if (sel_pen[i]) begin
            read_mux = state_reg.ports[i].pull_enable;
         end
         if (sel_alo[i]) begin
            read_mux = state_reg.ports[i].alt_function_select_low;
         end
         if (sel_ahi[i]) begin
            read_mux = state_reg.ports[i].alt_function_select_high;
         end
      end
   end

   // Next-state: writes update only the selected register.
   always_comb begin
      state_next = state_reg;
      if (sfr_req.rd) begin
         state_next.read_data = read_mux;
      end
      if (sfr_req.wr) begin
         if (sel_syscon) begin
            state_next.area_map_select = sfr_req.wdata[`AREA_MAP_SELECT_BIT];
         end
         if (sel_page) begin
            state_next.page = sfr_req.wdata & PAGE_MASK;
         end
         for (int i = 0; i < 6; i++) begin
            if (sel_pds[i]) begin
               state_next.ports[i].pull_direction_select = sfr_req.wdata;
            end
            if (sel_pen[i]) begin
               state_next.ports[i].pull_enable = sfr_req.wdata;
            end
            if (sel_alo[i]) begin
               state_next.ports[i].alt_function_select_low = sfr_req.wdata;
            end
            if (sel_ahi[i]) begin
               state_next.ports[i].alt_function_select_high = sfr_req.wdata;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg <= RESET_STATE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign sfr_claim       = sel_syscon || sel_page || (|sel_pds) || (|sel_pen)
                            || (|sel_alo) || (|sel_ahi);
   assign sfr_rdata       = state_reg.read_data;
   assign area_map_select = state_reg.area_map_select;
   assign port_page       = state_reg.page[PAGE_BITS-1:0];
   assign port_config     = state_reg.ports;

   // Checks.
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence syscon_read_seq;
      sfr_req.rd && sfr_req.addr == `SYSTEM_CONTROL_ZERO_ADDR;
   endsequence

   sequence pull_dir0_write_seq;
      sfr_req.wr && !area_map_select && port_page == `PORT_PAGE_PULL
      && sfr_req.addr == `PORT0_LOW_ADDR;
   endsequence

   sequence alt_high1_write_seq;
      sfr_req.wr && !area_map_select && port_page == `PORT_PAGE_ALT
      && sfr_req.addr == `PORT1_HIGH_ADDR;
   endsequence

   sequence map_write_seq;
      sfr_req.wr && sfr_req.addr == `SYSTEM_CONTROL_ZERO_ADDR;
   endsequence

   sequence map_set_seq;
      sfr_req.wr && sfr_req.addr == `SYSTEM_CONTROL_ZERO_ADDR
      && sfr_req.wdata[`AREA_MAP_SELECT_BIT];
   endsequence

   sequence alt_page_write_seq;
      sfr_req.wr && !area_map_select && sfr_req.addr == `MODULE_PAGE_REGISTER_ADDR
      && sfr_req.wdata == `PORT_PAGE_ALT;
   endsequence

   sequence port0_low_read_seq;
      sfr_req.rd && !area_map_select
      && sfr_req.addr == `PORT0_LOW_ADDR;
   endsequence

   sequence pull_en4_write_seq;
      sfr_req.wr && !area_map_select && port_page == `PORT_PAGE_PULL
      && sfr_req.addr == `PORT4_HIGH_ADDR;
   endsequence

   sequence alt_low3_write_seq;
      sfr_req.wr && !area_map_select && port_page == `PORT_PAGE_ALT
      && sfr_req.addr == `PORT3_LOW_ADDR;
   endsequence

   chk_claim_upper_half: assert property (
      !sfr_req.addr[7] |-> !sfr_claim)
      else $error("Claim asserted below the register range.");

   chk_syscon_read_value: assert property (
      syscon_read_seq |=> sfr_rdata == (`SYSTEM_CONTROL_ZERO_FIXED | 8'($past(area_map_select))))
      else $error("System control read value wrong.");

   chk_map_bit_write: assert property (
      map_write_seq |=> area_map_select == $past(sfr_req.wdata[0]))
      else $error("Map-select did not follow the write.");

   chk_map_bit_holds: assert property (
      !(sfr_req.wr && sfr_req.addr == `SYSTEM_CONTROL_ZERO_ADDR) |=> $stable(area_map_select))
      else $error("Map-select changed without a write.");

   chk_reset_defaults: assert property (
      $rose(rst_n) |-> !area_map_select
      && port_config[3].pull_direction_select == `PORT3_PULL_DIRECTION_RESET
      && port_config[0].pull_enable == `PORT0_PULL_ENABLE_RESET
      && port_config[4].pull_enable == `PORT4_PULL_ENABLE_RESET)
      else $error("Reset values wrong.");

   chk_pull_dir_write: assert property (
      pull_dir0_write_seq |=> port_config[0].pull_direction_select
      == $past(sfr_req.wdata) && port_config[0].alt_function_select_low
      == $past(port_config[0].alt_function_select_low))
      else $error("Page 1 write reached the wrong register.");

   chk_alt_high_write: assert property (
      alt_high1_write_seq |=> port_config[1].alt_function_select_high
      == $past(sfr_req.wdata) && port_config[1].pull_enable
      == $past(port_config[1].pull_enable))
      else $error("Page 2 write reached the wrong register.");

   chk_mapped_area_quiet: assert property (
      area_map_select && sfr_req.rd && sfr_req.addr != `SYSTEM_CONTROL_ZERO_ADDR
      |=> sfr_rdata == 8'h00)
      else $error("Mapped area read returned data.");

   chk_unclaimed_zero: assert property (
      sfr_req.rd && !sfr_claim |=> sfr_rdata == 8'h00)
      else $error("Unclaimed read returned data.");

   chk_page_field_mask: assert property (
      sfr_req.wr && !area_map_select && sfr_req.addr == `MODULE_PAGE_REGISTER_ADDR
      |=> port_page == $past(sfr_req.wdata[PAGE_BITS-1:0]))
      else $error("Page field write wrong.");

   chk_claim_syscon_both: assert property (
      sfr_req.addr == `SYSTEM_CONTROL_ZERO_ADDR |-> sfr_claim)
      else $error("System control not claimed.");

   chk_mapped_no_claim: assert property (
      area_map_select && sfr_req.addr != `SYSTEM_CONTROL_ZERO_ADDR |-> !sfr_claim)
      else $error("Mapped area claimed a standard register.");

   chk_page_gates_claim: assert property (
      !area_map_select && port_page != `PORT_PAGE_PULL && port_page != `PORT_PAGE_ALT
      && sfr_req.addr != `SYSTEM_CONTROL_ZERO_ADDR
      && sfr_req.addr != `MODULE_PAGE_REGISTER_ADDR |-> !sfr_claim)
      else $error("Port register claimed outside its pages.");

   chk_claim_pull_page: assert property (
      !area_map_select && port_page == `PORT_PAGE_PULL && sfr_req.addr == `PORT2_HIGH_ADDR
      |-> sfr_claim)
      else $error("Pull enable register not claimed.");

   chk_claim_alt_page: assert property (
      !area_map_select && port_page == `PORT_PAGE_ALT && sfr_req.addr == `PORT0_HIGH_ADDR
      |-> sfr_claim)
      else $error("Alternate select high register not claimed.");

   chk_rdata_holds: assert property (
      !sfr_req.rd |=> $stable(sfr_rdata))
      else $error("Read data changed without a read.");

   chk_page_read_value: assert property (
      sfr_req.rd && !area_map_select && sfr_req.addr == `MODULE_PAGE_REGISTER_ADDR
      |=> sfr_rdata == 8'($past(port_page)))
      else $error("Page register read value wrong.");

   chk_unclaimed_write_quiet: assert property (
      sfr_req.wr && !sfr_claim |=> $stable(port_config) && $stable(port_page)
      && $stable(area_map_select))
      else $error("Unclaimed write changed a register.");

   chk_pull_enable_write: assert property (
      pull_en4_write_seq |=> port_config[4].pull_enable == $past(sfr_req.wdata)
      && port_config[4].alt_function_select_high
      == $past(port_config[4].alt_function_select_high))
      else $error("Page 1 enable write reached the wrong register.");

   chk_alt_low_write: assert property (
      alt_low3_write_seq |=> port_config[3].alt_function_select_low == $past(sfr_req.wdata)
      && port_config[3].pull_direction_select
      == $past(port_config[3].pull_direction_select))
      else $error("Page 2 low write reached the wrong register.");

   chk_map_set_readback: assert property (
      map_set_seq ##1 syscon_read_seq
      |=> sfr_rdata == (`SYSTEM_CONTROL_ZERO_FIXED | (8'h01 << `AREA_MAP_SELECT_BIT)))
      else $error("Map-select set did not read back.");

   chk_page_then_access: assert property (
      alt_page_write_seq ##1 port0_low_read_seq
      |=> sfr_rdata == $past(port_config[0].alt_function_select_low))
      else $error("Page select did not route the next read.");

   chk_reset_pull_values: assert property (
      $rose(rst_n) |-> port_config[0].pull_direction_select == `PORT0_PULL_DIRECTION_RESET
      && port_config[5].pull_direction_select == `PORT5_PULL_DIRECTION_RESET
      && port_config[1].pull_enable == `PORT1_PULL_ENABLE_RESET
      && port_config[2].pull_enable == `PORT2_PULL_ENABLE_RESET
      && port_config[3].pull_enable == `PORT3_PULL_ENABLE_RESET
      && port_config[5].pull_enable == `PORT5_PULL_ENABLE_RESET)
      else $error("Pull reset values wrong.");

   chk_reset_alt_values: assert property (
      $rose(rst_n) |-> port_config[2].alt_function_select_low == `ALT_FUNCTION_RESET
      && port_config[5].alt_function_select_high == `ALT_FUNCTION_RESET
      && 8'(port_page) == `MODULE_PAGE_REGISTER_RESET
      && sfr_rdata == `READ_DATA_RESET)
      else $error("Page and alternate reset values wrong.");

endmodule

//--- sfr_map_defines.svh
`ifndef SFR_MAP_DEFINES_SVH
`define SFR_MAP_DEFINES_SVH

`define SFR_AREA_MSB                 7
`define SYSTEM_CONTROL_ZERO_ADDR     8'h8f
`define SYSTEM_CONTROL_ZERO_RESET    8'h04
`define SYSTEM_CONTROL_ZERO_FIXED    8'h04
`define AREA_MAP_SELECT_BIT          0
`define MODULE_PAGE_REGISTER_ADDR    8'hbe
`define MODULE_PAGE_REGISTER_RESET   8'h00
`define PORT_PAGE_PULL               8'h01
`define PORT_PAGE_ALT                8'h02
`define PORT_PAGE_BITS               3

`define PORT0_LOW_ADDR               8'h80
`define PORT0_HIGH_ADDR              8'h86
`define PORT1_LOW_ADDR               8'h90
`define PORT1_HIGH_ADDR              8'h91
`define PORT2_LOW_ADDR               8'ha0
`define PORT2_HIGH_ADDR              8'ha1
`define PORT3_LOW_ADDR               8'hb0
`define PORT3_HIGH_ADDR              8'hb1
`define PORT4_LOW_ADDR               8'hc8
`define PORT4_HIGH_ADDR              8'hc9
`define PORT5_LOW_ADDR               8'h92
`define PORT5_HIGH_ADDR              8'h93

`define PORT0_PULL_DIRECTION_RESET   8'hff
`define PORT1_PULL_DIRECTION_RESET   8'hff
`define PORT2_PULL_DIRECTION_RESET   8'hff
`define PORT3_PULL_DIRECTION_RESET   8'hbf
`define PORT4_PULL_DIRECTION_RESET   8'hff
`define PORT5_PULL_DIRECTION_RESET   8'hff
`define PORT0_PULL_ENABLE_RESET      8'hc4
`define PORT1_PULL_ENABLE_RESET      8'hff
`define PORT2_PULL_ENABLE_RESET      8'h00
`define PORT3_PULL_ENABLE_RESET      8'h40
`define PORT4_PULL_ENABLE_RESET      8'h04
`define PORT5_PULL_ENABLE_RESET      8'hff
`define ALT_FUNCTION_RESET           8'h00
`define READ_DATA_RESET              8'h00

`endif

//--- sfr_map_pkg.sv
package sfr_map_pkg;

   typedef struct packed {
      logic [7:0] pull_direction_select;
      logic [7:0] pull_enable;
      logic [7:0] alt_function_select_low;
      logic [7:0] alt_function_select_high;
   } port_config_type;

   typedef port_config_type [5:0] port_bank_type;

   typedef struct packed {
      logic [7:0] addr;
      logic       rd;
      logic       wr;
      logic [7:0] wdata;
   } sfr_request_type;

   typedef struct packed {
      logic          area_map_select;
      logic [7:0]    page;
      port_bank_type ports;
      logic [7:0]    read_data;
   } decoder_state_type;

endpackage

//--- cpu_model.sv
`timescale 1ns/1ps
module cpu_model (
   input  wire logic                    core_clk,
   output sfr_map_pkg::sfr_request_type sfr_req
);
   import sfr_map_pkg::*;

   initial begin
      sfr_req = '0;
   end

   // Places one access on the bus; the caller calls it just after a rising edge.
   task automatic drive(input logic [7:0] a, input logic r, input logic w, input logic [7:0] d);
      sfr_req <= '{addr: a, rd: r, wr: w, wdata: d};
   endtask

   // Releases the bus; address and data flip so that stale values never look valid.
   task automatic release_bus();
      sfr_req <= '{addr: ~sfr_req.addr, rd: 1'b0, wr: 1'b0, wdata: ~sfr_req.wdata};
   endtask
endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
   import sfr_map_pkg::*;
   logic            core_clk = 1'b0;
   logic            rst_n = 1'b0;
   sfr_request_type sfr_req;
   logic            sfr_claim;
   logic [7:0]      sfr_rdata;
   logic            area_map_select;
   logic [2:0]      port_page;
   port_bank_type   port_config;
   int              error_cnt = 0;
   int              check_count = 0;
   int              cyc = 0;
   int              seed = 73;
   logic [7:0]      q[$];
   logic            rd_d = 1'b0;
   logic [7:0]      m[4][6];
   logic            map_m;
   logic [2:0]      page_m;
   logic [7:0]      lo[6] = '{8'h80, 8'h90, 8'ha0, 8'hb0, 8'hc8, 8'h92};
   logic [7:0]      hi[6] = '{8'h86, 8'h91, 8'ha1, 8'hb1, 8'hc9, 8'h93};
   logic [7:0]      pdr[6] = '{8'hff, 8'hff, 8'hff, 8'hbf, 8'hff, 8'hff};
   logic [7:0]      per[6] = '{8'hc4, 8'hff, 8'h00, 8'h40, 8'h04, 8'hff};

   always #2.5 core_clk = ~core_clk;

   sfr_map_page_decoder uut (
      .core_clk        (core_clk),
      .rst_n           (rst_n),
      .sfr_req         (sfr_req),
      .sfr_claim       (sfr_claim),
      .sfr_rdata       (sfr_rdata),
      .area_map_select (area_map_select),
      .port_page       (port_page),
      .port_config     (port_config)
   );

   cpu_model cpu (
      .core_clk (core_clk),
      .sfr_req  (sfr_req)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Read data is compared one cycle after the read strobe was taken.
   always @(posedge core_clk) begin
      rd_d <= sfr_req.rd && rst_n;
      if (rd_d) check(sfr_rdata, q.pop_front(), "read data");
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end

   task automatic acc(input logic [7:0] a, input logic r, input logic w, input logic [7:0] d,
                      input logic [7:0] ex, input logic cl);
      cpu.drive(a, r, w, d);
      if (r) q.push_back(ex);
      #1 check(sfr_claim, cl, "claim");
      @(posedge core_clk);
   endtask

   task automatic set_page(input logic [2:0] pg);
      acc(8'hbe, 1'b0, 1'b1, {5'h00, pg}, 8'h00, 1'b1);
      page_m = pg;
   endtask

   task automatic reset_model();
      for (int p = 0; p < 6; p++) begin
         m[0][p] = pdr[p];
         m[1][p] = per[p];
         m[2][p] = 8'h00;
         m[3][p] = 8'h00;
      end
      map_m = 1'b0;
      page_m = 3'h0;
   endtask

   task automatic verify();
      for (int k = 0; k < 4; k++) begin
         if (k % 2 == 0) set_page(3'(k / 2 + 1));
         for (int p = 0; p < 6; p++) begin
            acc(k % 2 ? hi[p] : lo[p], 1'b1, 1'b0, 8'h00, m[k][p], 1'b1);
         end
      end
      acc(8'hbe, 1'b1, 1'b0, 8'h00, {5'h00, page_m}, 1'b1);
      acc(8'h8f, 1'b1, 1'b0, 8'h00, 8'h04 | {7'h00, map_m}, 1'b1);
      check(area_map_select, map_m, "map select");
      check(port_page, page_m, "page");
      for (int p = 0; p < 6; p++) begin
         check(port_config[p], {m[0][p], m[1][p], m[2][p], m[3][p]}, "port config");
      end
   endtask

   initial begin
      logic [7:0] v;
      reset_model();
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      verify();
      // Read and write in one cycle: the read returns the old value.
      for (int k = 0; k < 4; k++) begin
         if (k % 2 == 0) set_page(3'(k / 2 + 1));
         for (int p = 0; p < 6; p++) begin
            v = 8'($random(seed));
            acc(k % 2 ? hi[p] : lo[p], 1'b1, 1'b1, v, m[k][p], 1'b1);
            m[k][p] = v;
         end
      end
      verify();
      set_page(3'h0);
      acc(8'h80, 1'b1, 1'b1, 8'h5a, 8'h00, 1'b0);
      set_page(3'h3);
      acc(8'h91, 1'b1, 1'b1, 8'h5a, 8'h00, 1'b0);
      acc(8'h8f, 1'b1, 1'b0, 8'h00, 8'h04, 1'b1);
      acc(8'h8f, 1'b0, 1'b1, 8'h04 | 8'h01, 8'h00, 1'b1);
      map_m = 1'b1;
      acc(8'h8f, 1'b1, 1'b0, 8'h00, 8'h05, 1'b1);
      acc(8'h80, 1'b1, 1'b1, 8'h33, 8'h00, 1'b0);
      cpu.release_bus();
      repeat (40) @(posedge core_clk);
      check(area_map_select, 1'b1, "map held");
      acc(8'h8f, 1'b0, 1'b1, 8'h04, 8'h00, 1'b1);
      map_m = 1'b0;
      verify();
      cpu.release_bus();
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      reset_model();
      @(posedge core_clk);
      verify();
      cpu.release_bus();
      repeat (3) @(posedge core_clk);
      wrap_up();
   end
endmodule
